// File: design/hro_map.svh
// Offsets, field positions, reset values and source codes of the options register.
`ifndef HRO_MAP_SVH
`define HRO_MAP_SVH
`define HRO_OPT_OFFSET       10'h01d
`define HRO_OPT_RESET        8'h80
`define HRO_OPT_WMASK        8'hfb
`define HRO_BIT_STATUS_MEM   7
`define HRO_BIT_CRYSTAL_AMP  6
`define HRO_BIT_DOUBLER      5
`define HRO_BIT_FREEZE_PLLST 4
`define HRO_BIT_LOCK_CMP     3
`define HRO_BIT_UNUSED       2
`define HRO_BIT_EXT_HOLD     1
`define HRO_BIT_HOLD_EN      0
`define HRO_SRC_WIDTH        6
`define HRO_SRC_LOCK_CMP     6'h3f
`endif

// File: design/hro_pkg.sv
// Types shared by the holdover and reference options block.
`default_nettype none
package hro_pkg;
  typedef struct packed {
    logic       write;
    logic       read;
    logic [9:0] addr;
    logic [7:0] wdata;
  } hro_req_type;

  typedef struct packed {
    logic status_from_memory;
    logic crystal_amp_en;
    logic doubler_en;
    logic pll_status_frozen;
    logic lock_cmp_en;
    logic ext_hold_sel;
    logic holdover_en;
  } hro_ctrl_type;
endpackage : hro_pkg
`default_nettype wire

// File: design/hro_options.sv
// Holdover and reference options register with its control decode.
`timescale 1ns/1ps
`default_nettype none
`include "hro_map.svh"

// How it works
// [R1] Bit 7 set: status pin shows memory flag.
// [R2] Bit 7 clear: status pin uses selection field.
// [R3] Bit 6 enables the crystal amplifier.
// [R4] Bit 5 enables the reference doubler.
// [R5] Bit 4 set freezes PLL status readback.
// [R6] Bit 3 and auto holdover: comparator decides lock.
// [R7] Bit 3 clear: lock input treated high.
// [R8] Bit 3 outside auto holdover: comparator observable.
// [R9] Bit 1 selects external hold pin control.
// [R10] Bit 0 enables internal holdover function.
// [R11] Bit 2 ignores writes, reads zero.
module hro_options
  import hro_pkg::*;
(
  // Clock and reset.
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  // Serial port register access.
  input  wire hro_req_type               req,
  output logic [7:0]                     rdata,
  // Status sources.
  input  wire logic                      mem_xfer_flag,
  input  wire logic [`HRO_SRC_WIDTH-1:0] status_sel,
  input  wire logic [`HRO_SRC_WIDTH-1:0] sel_status_src,
  input  wire logic                      lock_detect_pin,
  input  wire logic                      ext_hold_pin,
  // Control outputs.
  output hro_ctrl_type                   ctrl,
  output logic                           status_pin,
  output logic                           reference_monitor_pin,
  output logic                           prev_locked,
  output logic                           hold_request,
  output logic                           pll_status_update
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [1:0] lock_sync_q, lock_sync_d;
  logic [1:0] hold_sync_q, hold_sync_d;
  logic       lock_level;
  logic       auto_mode;

  always_comb
  begin
    lock_sync_d = {lock_sync_q[0], lock_detect_pin};
    hold_sync_d = {hold_sync_q[0], ext_hold_pin};
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lock_sync_q <= 2'h0;
      hold_sync_q <= 2'h0;
    end
    else
    begin
      lock_sync_q <= lock_sync_d;
      hold_sync_q <= hold_sync_d;
    end
  end

  assign lock_level = lock_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Register and readback.
  logic [7:0] opt_q, opt_d;
  logic [7:0] rdata_q, rdata_d;
  logic       hit;

  assign hit = (req.addr == `HRO_OPT_OFFSET);

  always_comb
  begin
    opt_d   = opt_q;
    rdata_d = rdata_q;
    if (req.write && hit)
    begin
      opt_d = req.wdata & `HRO_OPT_WMASK; // [R11]
    end
    if (req.read)
    begin
      rdata_d = hit ? opt_q : 8'h00;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      opt_q   <= `HRO_OPT_RESET;
      rdata_q <= 8'h00;
    end
    else
    begin
      opt_q   <= opt_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Control decode, registered.
  hro_ctrl_type ctrl_d, ctrl_q;
  logic [4:0]   pins_d, pins_q;
  logic         lock_cmp;
  logic         st_d, rm_d, pl_d, hr_d, pu_d;

  always_comb
  begin
    ctrl_d.status_from_memory = opt_q[`HRO_BIT_STATUS_MEM]; // [R1]
    ctrl_d.crystal_amp_en     = opt_q[`HRO_BIT_CRYSTAL_AMP]; // [R3]
    ctrl_d.doubler_en         = opt_q[`HRO_BIT_DOUBLER]; // [R4]
    ctrl_d.pll_status_frozen  = opt_q[`HRO_BIT_FREEZE_PLLST]; // [R5]
    ctrl_d.lock_cmp_en        = opt_q[`HRO_BIT_LOCK_CMP]; // [R6]
    ctrl_d.ext_hold_sel       = opt_q[`HRO_BIT_EXT_HOLD]; // [R9]
    ctrl_d.holdover_en        = opt_q[`HRO_BIT_HOLD_EN]; // [R10]
    auto_mode = opt_q[`HRO_BIT_HOLD_EN] && !opt_q[`HRO_BIT_EXT_HOLD];
    lock_cmp  = opt_q[`HRO_BIT_LOCK_CMP] && lock_level;
    pl_d = opt_q[`HRO_BIT_LOCK_CMP] ? lock_level : 1'b1; // [R6] [R7]
    if (opt_q[`HRO_BIT_STATUS_MEM])
      st_d = mem_xfer_flag; // [R1]
    else if (!auto_mode && status_sel == `HRO_SRC_LOCK_CMP)
      st_d = lock_cmp; // [R8]
    else
      st_d = sel_status_src[0]; // [R2]
    rm_d = auto_mode ? 1'b0 : lock_cmp; // [R8]
    hr_d = opt_q[`HRO_BIT_EXT_HOLD] && hold_sync_q[1]; // [R9]
    pu_d = !opt_q[`HRO_BIT_FREEZE_PLLST]; // [R5]
    pins_d = {st_d, rm_d, pl_d, hr_d, pu_d};
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q <= '0;
      pins_q <= 5'h00;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      pins_q <= pins_d;
    end
  end

  assign ctrl = ctrl_q;
  assign {status_pin, reference_monitor_pin, prev_locked, hold_request,
          pll_status_update} = pins_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_unused_bit_zero: assert property ( // [R11]
    @(posedge core_clk) disable iff (sys_rst)
    opt_q[`HRO_BIT_UNUSED] == 1'b0)
    else $error("unused bit set");

  a_status_memory: assert property ( // [R1]
    @(posedge core_clk) disable iff (sys_rst)
    opt_q[7] |=> status_pin == $past(mem_xfer_flag))
    else $error("status pin not memory flag");

  a_status_select: assert property ( // [R2]
    @(posedge core_clk) disable iff (sys_rst)
    (!opt_q[7] && status_sel != `HRO_SRC_LOCK_CMP)
      |=> status_pin == $past(sel_status_src[0]))
    else $error("status pin not selected source");

  a_status_lock: assert property ( // [R8]
    @(posedge core_clk) disable iff (sys_rst)
    (!opt_q[7] && (!opt_q[0] || opt_q[1])
      && status_sel == `HRO_SRC_LOCK_CMP)
      |=> status_pin == ($past(opt_q[3]) && $past(lock_level)))
    else $error("status pin not lock comparator");

  a_crystal_amp: assert property ( // [R3]
    @(posedge core_clk) disable iff (sys_rst)
    ##1 ctrl.crystal_amp_en == $past(opt_q[6]))
    else $error("crystal amp mismatch");

  a_doubler_en: assert property ( // [R4]
    @(posedge core_clk) disable iff (sys_rst)
    ##1 ctrl.doubler_en == $past(opt_q[5]))
    else $error("doubler mismatch");

  a_freeze_update: assert property ( // [R5]
    @(posedge core_clk) disable iff (sys_rst)
    opt_q[4] |=> !pll_status_update)
    else $error("status update not frozen");

  a_lock_ignored: assert property ( // [R7]
    @(posedge core_clk) disable iff (sys_rst)
    !opt_q[3] |=> prev_locked)
    else $error("lock input not forced high");

  a_lock_used: assert property ( // [R6]
    @(posedge core_clk) disable iff (sys_rst)
    opt_q[3] |=> prev_locked == $past(lock_level))
    else $error("lock comparator not used");

  a_ext_hold: assert property ( // [R9]
    @(posedge core_clk) disable iff (sys_rst)
    !opt_q[1] |=> !hold_request)
    else $error("hold pin used in auto mode");

  a_hold_pin: assert property ( // [R9]
    @(posedge core_clk) disable iff (sys_rst)
    opt_q[1] |=> hold_request == $past(hold_sync_q[1]))
    else $error("hold pin not followed");

  a_hold_enable: assert property ( // [R10]
    @(posedge core_clk) disable iff (sys_rst)
    ##1 ctrl.holdover_en == $past(opt_q[0]))
    else $error("holdover enable mismatch");

  a_reference_monitor_pin_auto: assert property ( // [R8]
    @(posedge core_clk) disable iff (sys_rst)
    (opt_q[0] && !opt_q[1]) |=> !reference_monitor_pin)
    else $error("monitor pin driven in auto mode");

endmodule : hro_options
`default_nettype wire

// File: verification/hro_options_tb_top.sv
// Self-checking bench for the holdover and reference options block.
`timescale 1ns/1ps
`default_nettype none
module hro_options_tb_top;
  import hro_pkg::*;
  logic         core_clk = 1'b0;
  logic         sys_rst  = 1'b1;
  hro_req_type  req      = '0;
  logic         mem_flag = 1'b0;
  logic         lock     = 1'b0;
  logic         hold     = 1'b0;
  logic [5:0]   sel      = 6'h00;
  logic [5:0]   src      = 6'h00;
  logic [7:0]   rdata;
  hro_ctrl_type ctrl;
  logic         st;
  logic         rmon;
  logic         prev;
  logic         hreq;
  logic         upd;
  int           fails     = 0;
  int           tests_run = 0;
  logic [31:0]  seed      = 32'hd3eaeff9;
  logic [31:0]  w;
  logic [7:0]   opt       = 8'h80;
  logic [7:0]   nopt;
  logic         a;
  logic         c;
  logic         exp_st;

  hro_options hro_options_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
    .mem_xfer_flag(mem_flag), .status_sel(sel), .sel_status_src(src),
    .lock_detect_pin(lock), .ext_hold_pin(hold), .ctrl(ctrl),
    .status_pin(st), .reference_monitor_pin(rmon), .prev_locked(prev),
    .hold_request(hreq), .pll_status_update(upd)
  );

  always #2 core_clk = ~core_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic end_of_test();
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic check_all();
    a = opt[0] & ~opt[1];
    c = opt[3] & lock;
    exp_st = opt[7] ? mem_flag : (!a && sel == 6'h3f) ? c : src[0];
    chk({1'b0, ctrl}, {1'b0, opt[7:3], opt[1:0]});
    chk({7'h00, st}, {7'h00, exp_st});
    chk({7'h00, rmon}, {7'h00, a ? 1'b0 : c});
    chk({7'h00, prev}, {7'h00, opt[3] ? lock : 1'b1});
    chk({7'h00, hreq}, {7'h00, opt[1] & hold});
    chk({7'h00, upd}, {7'h00, ~opt[4]});
  endtask : check_all

  initial
  begin
    #20000;
    fails++;
    end_of_test();
  end

  initial
  begin
    repeat (6) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge core_clk);
    check_all();
    for (int i = 0; i < 200; i++)
    begin
      seed = lfsr(seed);
      w = seed;
      mem_flag = w[8];
      lock = w[9];
      hold = w[10];
      sel = w[11] ? 6'h3f : w[16:11];
      src = w[22:17];
      nopt = (w[25:24] != 2'b00) ? (w[7:0] & 8'hfb) : opt;
      if (nopt[0] & ~nopt[1] & (sel == 6'h3f))
        sel = 6'h00;
      req.write = 1'b1;
      req.addr = (w[25:24] != 2'b00) ? 10'h01d : {2'b00, w[31:26], 2'b10};
      req.wdata = w[7:0];
      @(negedge core_clk);
      opt = nopt;
      req.write = 1'b0;
      req.read = 1'b1;
      req.addr = w[27] ? 10'h01d : 10'h01c;
      @(negedge core_clk);
      req.read = 1'b0;
      chk(rdata, w[27] ? opt : 8'h00);
      repeat (4) @(negedge core_clk);
      check_all();
    end
    end_of_test();
  end
endmodule : hro_options_tb_top
`default_nettype wire
